// File: csp_peer.sv
// Model of an external serial slave on select line 0, leading-edge sampling.
// Assumes select active low and the master shifting MSB first.
`timescale 1ns/1ns
module csp_peer (
  // Serial pins from the master
  input  wire logic        sclk,
  input  wire logic        ss_n,
  input  wire logic        mosi,
  // Reply word and results
  input  wire logic [31:0] reply,
  output logic             miso,
  output logic      [31:0] got,
  output int               words,
  output int               frames
);
  logic [31:0] txs;
  logic [31:0] rxs;
  int          bits;
  initial begin
    miso = 1'b0;
    got = 32'h0;
    rxs = 32'h0;
    txs = 32'h0;
    words = 0;
    frames = 0;
    bits = 0;
  end
  // Select start loads the reply; release shows the inverse, never a stale bit
  always @(negedge ss_n) begin
    txs = reply;
    bits = 0;
    miso = reply[31];
    frames++;
  end
  always @(posedge ss_n) miso = ~miso;
  // Sample on the leading edge, a whole word each 32 samples
  always @(posedge sclk) begin
    if (!ss_n) begin
      rxs = {rxs[30:0], mosi};
      bits++;
      if (bits == 32) begin
        got = rxs;
        words++;
        bits = 0;
        txs = reply;
      end
    end
  end
  // Next bit on the trailing edge
  always @(negedge sclk) if (!ss_n) miso = txs[31 - bits];
endmodule : csp_peer

// File: csp_pkg.sv
// Constants for the configurable serial port: register map, fields, resets.
// Assumes an APB master with 32-bit data and byte addresses.
package csp_pkg;
  // Queue geometry
  localparam int DW    = 32;
  localparam int DEPTH = 8;
  localparam int AW    = 3;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STAT   = 8'h04;
  localparam logic [7:0] OFS_TXDATA = 8'h08;
  localparam logic [7:0] OFS_RXDATA = 8'h0C;
  localparam logic [7:0] OFS_PERIOD = 8'h10;
  localparam logic [7:0] OFS_INTEN  = 8'h14;
  localparam logic [7:0] OFS_INTCLR = 8'h18;
  localparam logic [7:0] OFS_INTST  = 8'h1C;
  // Control field positions
  localparam int C_EN    = 0;
  localparam int C_MST   = 1;
  localparam int C_CPOL  = 2;
  localparam int C_CPHA  = 3;
  localparam int C_SSPOL = 4;
  localparam int C_CONT  = 8;
  localparam int C_RDY   = 9;
  localparam int C_SEL   = 10;
  localparam int C_DIV   = 12;
  localparam int C_DTX   = 20;
  localparam int C_DRX   = 21;
  // Interrupt bit positions
  localparam int I_TXE  = 0;
  localparam int I_RXR  = 1;
  localparam int I_OVF  = 2;
  localparam int I_DONE = 3;
  // Reset values
  localparam logic [31:0] CTRL_RST   = 32'h0000_2000;
  localparam logic [15:0] PERIOD_RST = 16'h0000;
  localparam logic [3:0]  INTEN_RST  = 4'h0;
  // Half period floor: two pclk per half keeps serial clock at most a quarter
  localparam logic [7:0] DIV_MIN   = 8'h02;
  localparam logic [5:0] EDGE_LAST = 6'h3F;
  localparam logic [4:0] BIT_LAST  = 5'h1F;
  // Master sequencer
  typedef enum logic [1:0] {MS_IDLE, MS_SHIFT, MS_GAP} csp_state_e;
endpackage : csp_pkg

// File: csp_props.sv
// Checker for the serial port top: bus answer, pin roles, clock pacing.
// Assumes the tests keep select polarity at reset, so inactive lines read 1.
`timescale 1ns/1ns
module csp_props import csp_pkg::*; (
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // APB
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  // Pins
  input wire logic       port_serial_clock_pin_out,
  input wire logic       port_serial_clock_pin_oe,
  input wire logic [3:0] port_select_line_in,
  input wire logic [3:0] port_select_line_out,
  input wire logic [3:0] port_select_line_oe,
  input wire logic       mosi_oe,
  input wire logic       miso_oe,
  // Requests
  input wire logic       tx_dma_req,
  input wire logic       rx_dma_req,
  input wire logic       irq
);
  logic acc;
  // Completed access, the only edge at which a transfer takes effect
  assign acc = psel && penable && pready;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_SCLK_HALF: assert property ($changed(port_serial_clock_pin_out) |=> $stable(port_serial_clock_pin_out))
    else $error("serial clock half period below two cycles");
  AST_ONE_SELECT: assert property (port_serial_clock_pin_oe |-> $countones(~port_select_line_out) <= 1)
    else $error("more than one select active");
  AST_SCLK_SELECTED: assert property (port_serial_clock_pin_oe && $changed(port_serial_clock_pin_out)
    |-> port_select_line_out != 4'hF)
    else $error("serial clock moved with no select active");
  AST_MASTER_PINS: assert property (port_serial_clock_pin_oe
    |-> mosi_oe && port_select_line_oe == 4'hF && !miso_oe)
    else $error("master pin drive wrong");
  AST_PREADY_PULSE: assert property (pready |-> psel && penable ##1 !pready)
    else $error("ready outside access or longer than one cycle");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_TXDMA_DROP: assert property (acc && pwrite && paddr == OFS_TXDATA |=> !tx_dma_req)
    else $error("tx request not dropped after write");
  AST_RXDMA_DROP: assert property (acc && !pwrite && paddr == OFS_RXDATA |=> !rx_dma_req)
    else $error("rx request not dropped after read");
  AST_SLAVE_SEL: assert property ($rose(miso_oe) |-> !$past(port_select_line_in[0], 2))
    else $error("slave drive without select");
  // Main scenarios reached
  cover property ($fell(port_select_line_out[0]));
  cover property ($rose(miso_oe));
  cover property (pslverr);
  cover property ($rose(irq));
endmodule : csp_props

bind csp_top csp_props i_props (.*);

// File: csp_top.sv
// Configurable serial port, master or slave, with transmit and receive queues.
// Assumes pins arrive asynchronously and are synchronised here; APB on pclk.
// Operation
// - Full duplex four wire link, one word out while one word comes in.
// - Receive and transmit queues of eight 32-bit entries each.
// - Software picks master or slave role; pin behaviour follows it.
// - Four select lines, one chosen per transfer.
// - Continuation keeps select asserted across words for unlimited length.
// - Software sets select polarities, clock idle level and sampling phase.
// - Serial clock never faster than a quarter of the reference clock.
// - Master drives serial clock and asserts exactly one chosen select.
// - Master may wait on a ready line that the slave drives.
// - Master inserts a programmable sample period between words.
// - Slave samples with configured polarity and phase matching the master.
// - Slave select input gates shifting and triggers queue load; the 32nd sample of each word triggers the store.
// - DMA requests fill the transmit queue and empty the receive queue.
`timescale 1ns/1ns
module csp_queue (
  // Clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // Write side
  input  wire logic                    push,
  input  wire logic [csp_pkg::DW-1:0]  wdata,
  // Read side
  input  wire logic                    pop,
  output logic      [csp_pkg::DW-1:0]  head,
  // Fill state
  output logic                         full,
  output logic                         empty,
  output logic      [csp_pkg::AW:0]    count
);
  import csp_pkg::*;
  logic [DW-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic          do_push;
  logic          do_pop;

  // Refused pushes and pops keep the pointers honest
  assign do_push = push & ~full;
  assign do_pop  = pop & ~empty;
  assign full    = count[AW];
  assign empty   = (count == '0);
  assign head    = mem[rp];

  // Pointers and fill count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp    <= '0;
      rp    <= '0;
      count <= '0;
    end else begin
      if (do_push) wp <= wp + 1'b1;
      if (do_pop) rp <= rp + 1'b1;
      count <= count + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
    end
  end

  // Storage, written by index
  always_ff @(posedge pclk) begin
    if (do_push) mem[wp] <= wdata;
  end
endmodule : csp_queue

module csp_top (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial clock pin
  input  wire logic        port_serial_clock_pin_in,
  output logic             port_serial_clock_pin_out,
  output logic             port_serial_clock_pin_oe,
  // Select lines, line 0 is the slave input
  input  wire logic [3:0]  port_select_line_in,
  output logic      [3:0]  port_select_line_out,
  output logic      [3:0]  port_select_line_oe,
  // Data pins
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe,
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe,
  // Slave ready handshake
  input  wire logic        peer_ready,
  // DMA and interrupt
  output logic             tx_dma_req,
  output logic             rx_dma_req,
  output logic             irq
);
  import csp_pkg::*;
  logic [31:0]    ctrl;
  logic [15:0]    period;
  logic [3:0]     int_en;
  logic [3:0]     int_st;
  logic [4:0]     sy1;
  logic [4:0]     sy2;
  logic [1:0]     sy3;
  csp_state_e     state;
  logic [7:0]     hcnt;
  logic [7:0]     half;
  logic [15:0]    gcnt;
  logic [5:0]     edge_n;
  logic           ss_act;
  logic           sclk_q;
  logic [31:0]    txsh;
  logic [31:0]    rxsh;
  logic           sdo;
  logic [4:0]     bcnt;
  logic           s_act_d;
  logic [31:0]    tx_head;
  logic [31:0]    rx_head;
  logic           tx_full;
  logic           tx_empty;
  logic           rx_full;
  logic           rx_empty;
  logic [3:0]     tx_cnt;
  logic [3:0]     rx_cnt;
  logic           acc;
  logic           wr;
  logic           rd;
  logic [31:0]    rd_val;
  logic           mapped;
  logic           en;
  logic           mst;
  logic           cpha;
  logic           tick;
  logic           go;
  logic           m_start;
  logic           m_edge;
  logic           m_samp;
  logic           m_last;
  logic           s_act;
  logic           s_start;
  logic           s_end;
  logic           sc_chg;
  logic           s_samp;
  logic           s_drv;
  logic           s_word;
  logic           ld;
  logic           samp;
  logic           drv;
  logic           din;
  logic [31:0]    word;
  logic           tx_pop;
  logic           tx_push;
  logic           rx_push;
  logic           rx_pop;
  logic [31:0]    rx_wdata;
  logic [3:0]     ev;

  assign en   = ctrl[C_EN];
  assign mst  = ctrl[C_MST];
  assign cpha = ctrl[C_CPHA];

  // Two-stage synchronisers: sclk, ss0, mosi, miso, ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sy1 <= '0;
      sy2 <= '0;
      sy3 <= '0;
    end else begin
      sy1 <= {peer_ready, miso_in, mosi_in, port_select_line_in[0], port_serial_clock_pin_in};
      sy2 <= sy1;
      sy3 <= sy2[1:0]; // Edge history reads only the second stage
    end
  end

  // APB: one wait state so read data comes from a flop
  assign acc = psel & penable & pready;
  assign wr  = acc & pwrite;
  assign rd  = acc & ~pwrite;
  always_comb begin
    rd_val = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      OFS_CTRL:   rd_val = ctrl;
      OFS_STAT:   rd_val = {16'h0000, 3'h0, ss_act | s_act_d, rx_cnt, 4'h0, tx_cnt};
      OFS_TXDATA: rd_val = 32'h0000_0000;
      OFS_RXDATA: rd_val = rx_empty ? 32'h0000_0000 : rx_head;
      OFS_PERIOD: rd_val = {16'h0000, period};
      OFS_INTEN:  rd_val = {28'h0000000, int_en};
      OFS_INTCLR: rd_val = 32'h0000_0000;
      OFS_INTST:  rd_val = {28'h0000000, int_st};
      default:    mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (psel & penable & ~pready) prdata <= rd_val;
    end
  end

  // Software registers; the role and phase fields steer the shifter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl   <= CTRL_RST;
      period <= PERIOD_RST;
      int_en <= INTEN_RST;
    end else if (wr) begin
      if (paddr == OFS_CTRL) ctrl <= pwdata;
      if (paddr == OFS_PERIOD) period <= pwdata[15:0];
      if (paddr == OFS_INTEN) int_en <= pwdata[3:0];
    end
  end

  // Queues between software and the shift register
  assign tx_push = wr & (paddr == OFS_TXDATA);
  assign rx_pop  = rd & (paddr == OFS_RXDATA);
  csp_queue u_txq (
    .pclk    (pclk),
    .presetn (presetn),
    .push    (tx_push),
    .wdata   (pwdata),
    .pop     (tx_pop),
    .head    (tx_head),
    .full    (tx_full),
    .empty   (tx_empty),
    .count   (tx_cnt)
  );
  csp_queue u_rxq (
    .pclk    (pclk),
    .presetn (presetn),
    .push    (rx_push),
    .wdata   (rx_wdata),
    .pop     (rx_pop),
    .head    (rx_head),
    .full    (rx_full),
    .empty   (rx_empty),
    .count   (rx_cnt)
  );

  // Master timing terms
  assign half    = (ctrl[C_DIV +: 8] < DIV_MIN) ? DIV_MIN : ctrl[C_DIV +: 8];
  assign tick    = (hcnt == half - 8'h01);
  assign go      = en & mst & ~tx_empty & (~ctrl[C_RDY] | sy2[4]);
  assign m_start = (state == MS_IDLE) & go;
  assign m_edge  = (state == MS_SHIFT) & tick;
  assign m_samp  = m_edge & (edge_n[0] == cpha);
  assign m_last  = m_edge & (edge_n == EDGE_LAST);

  // Master sequencer: start, 64 half periods, gap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state  <= MS_IDLE;
      hcnt   <= 8'h00;
      gcnt   <= 16'h0000;
      edge_n <= 6'h00;
      ss_act <= 1'b0;
      sclk_q <= 1'b0;
    end else if (!(en & mst)) begin
      state  <= MS_IDLE;
      ss_act <= 1'b0;
      sclk_q <= ctrl[C_CPOL];
    end else begin
      case (state)
        MS_IDLE: begin
          sclk_q <= ctrl[C_CPOL];
          if (m_start) begin
            ss_act <= 1'b1;
            hcnt   <= 8'h00;
            edge_n <= 6'h00;
            state  <= MS_SHIFT;
          end else begin
            ss_act <= ss_act & ctrl[C_CONT];
          end
        end
        MS_SHIFT: begin
          hcnt <= tick ? 8'h00 : hcnt + 8'h01;
          if (tick) begin
            sclk_q <= ~sclk_q;
            edge_n <= edge_n + 6'h01;
            if (m_last) begin
              gcnt  <= 16'h0000;
              state <= MS_GAP;
            end
          end
        end
        MS_GAP: begin
          ss_act <= ctrl[C_CONT];
          gcnt   <= gcnt + 16'h0001;
          if (gcnt >= period) state <= MS_IDLE;
        end
        default: state <= MS_IDLE;
      endcase
    end
  end

  // Slave terms from synchronised pins
  assign s_act   = en & ~mst & (sy2[1] == ctrl[C_SSPOL]);
  assign s_start = s_act & ~s_act_d;
  assign s_end   = ~s_act & s_act_d;
  assign sc_chg  = s_act & (sy2[0] ^ sy3[0]);
  assign s_samp  = sc_chg & ((sy3[0] == ctrl[C_CPOL]) ^ cpha);
  assign s_drv   = sc_chg & ~s_samp;
  assign s_word  = s_samp & (bcnt == BIT_LAST);

  // Shared shift path for both roles
  assign ld       = m_start | s_start;
  assign samp     = m_samp | s_samp;
  assign drv      = (m_edge & ~m_samp) | s_drv;
  assign din      = mst ? sy2[3] : sy2[2];
  assign word     = tx_empty ? 32'h0000_0000 : tx_head; // Underrun sends zeros
  assign tx_pop   = m_start | ((s_start | s_word) & ~tx_empty);
  assign rx_push  = m_last | s_word;
  assign rx_wdata = (m_last & ~m_samp) ? rxsh : {rxsh[30:0], din};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txsh    <= 32'h0000_0000;
      rxsh    <= 32'h0000_0000;
      sdo     <= 1'b0;
      bcnt    <= 5'h00;
      s_act_d <= 1'b0;
    end else begin
      s_act_d <= s_act;
      if (ld) begin
        txsh <= cpha ? word : {word[30:0], 1'b0};
        bcnt <= 5'h00;
        if (!cpha) sdo <= word[31];
      end else if (s_word) begin
        txsh <= word; // Next word goes out on the following drive edge
      end else if (drv) begin
        sdo  <= txsh[31];
        txsh <= {txsh[30:0], 1'b0};
      end
      if (samp) begin
        rxsh <= {rxsh[30:0], din};
        bcnt <= bcnt + 5'h01;
      end
    end
  end

  // Pin drivers; only the chosen select goes active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_serial_clock_pin_out <= 1'b0;
      port_serial_clock_pin_oe  <= 1'b0;
      port_select_line_out      <= 4'h0;
      port_select_line_oe       <= 4'h0;
      mosi_out                  <= 1'b0;
      mosi_oe                   <= 1'b0;
      miso_out                  <= 1'b0;
      miso_oe                   <= 1'b0;
    end else begin
      port_serial_clock_pin_out <= sclk_q;
      port_serial_clock_pin_oe  <= en & mst;
      for (int i = 0; i < 4; i++) begin
        port_select_line_out[i] <= (ss_act && ctrl[C_SEL +: 2] == i[1:0]) ?
                                   ctrl[C_SSPOL + i] : ~ctrl[C_SSPOL + i];
      end
      port_select_line_oe <= {4{en & mst}};
      mosi_out            <= sdo;
      mosi_oe             <= en & mst;
      miso_out            <= sdo;
      miso_oe             <= s_act; // Released while deselected so slaves share the wire
    end
  end

  // DMA requests, levels while room or data exists
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_dma_req <= 1'b0;
      rx_dma_req <= 1'b0;
    end else begin
      tx_dma_req <= ctrl[C_DTX] & ~tx_full & ~tx_push;
      rx_dma_req <= ctrl[C_DRX] & ~rx_empty & ~rx_pop;
    end
  end

  // Sticky status; a new event beats a clear in the same cycle
  assign ev[I_TXE]  = en & tx_empty;
  assign ev[I_RXR]  = ~rx_empty;
  assign ev[I_OVF]  = rx_push & rx_full;
  assign ev[I_DONE] = m_last | s_end;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_st <= 4'h0;
      irq    <= 1'b0;
    end else begin
      int_st <= (int_st & ~((wr && paddr == OFS_INTCLR) ? pwdata[3:0] : 4'h0)) | ev;
      irq    <= |(int_st & int_en);
    end
  end
endmodule : csp_top

// File: csp_top_tb_top.sv
// Testbench for the serial port: APB tasks, master and slave scenarios.
// Assumes the peer model on select line 0 and the bench as external master.
`timescale 1ns/1ns
module csp_top_tb_top;
  import csp_pkg::*;
  localparam logic [31:0] REPLY = 32'hA5C3_0F96;
  logic        pclk, presetn, psel, penable, pwrite, sclk_in, mosi_in, peer_ready, err;
  logic        pready, pslverr, sclk_out, sclk_oe, mosi_out, mosi_oe, miso_in, miso_out, miso_oe;
  logic        tx_dma_req, rx_dma_req, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, got;
  logic [3:0]  ss_in, ss_out, ss_oe;
  int          words, frames, f0, i, m;
  int          mismatches = 0;
  int          checks_done = 0;
  int          cyc = 0;
  csp_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_serial_clock_pin_in(sclk_in), .port_serial_clock_pin_out(sclk_out),
    .port_serial_clock_pin_oe(sclk_oe), .port_select_line_in(ss_in), .port_select_line_out(ss_out),
    .port_select_line_oe(ss_oe), .mosi_in(mosi_in), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
    .miso_in(miso_in), .miso_out(miso_out), .miso_oe(miso_oe), .peer_ready(peer_ready),
    .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req), .irq(irq));
  csp_peer i_peer (.sclk(sclk_out), .ss_n(ss_out[0]), .mosi(mosi_out), .reply(REPLY), .miso(miso_in),
    .got(got), .words(words), .frames(frames));
  // Clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Hang guard, generous against some four thousand cycles of tests
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      print_verdict();
    end
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One APB transfer; request held until ready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    chk("pready", pready, 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wait_words(input int n);
    int k;
    for (k = 0; k < 5000 && words < n; k++) @(posedge pclk);
    chk("peer words", words, n);
    repeat (4) @(posedge pclk);
  endtask : wait_words
  // External master frame; clock of 80 ns stands at idle level outside it
  task slave_frame(input logic cpol, input logic [31:0] w, input logic [31:0] t);
    int b;
    logic [31:0] rs;
    rs = 32'h0000_0000;
    // Settle the clock at its idle level before select, so no false edge opens the frame
    sclk_in <= cpol;
    repeat (4) @(posedge pclk);
    ss_in <= 4'hE;
    mosi_in <= w[31];
    repeat (8) @(posedge pclk);
    for (b = 0; b < 32; b++) begin
      sclk_in <= ~cpol;
      // Data out is settled one cycle after the sampling edge is launched
      @(posedge pclk);
      rs = {rs[30:0], miso_out};
      repeat (3) @(posedge pclk);
      sclk_in <= cpol;
      mosi_in <= (b < 31) ? w[30 - b] : ~w[0];
      repeat (4) @(posedge pclk);
    end
    chk("miso_oe on", miso_oe, 1'b1);
    chk("slave tx", rs, t);
    ss_in <= 4'hF;
    repeat (8) @(posedge pclk);
  endtask : slave_frame
  task print_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, sclk_in, mosi_in} = 6'h0;
    {paddr, pwdata} = 40'h0;
    peer_ready = 1'b1;
    ss_in = 4'hF;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFS_CTRL, 0);
    chk("ctrl reset", q, CTRL_RST);
    apb(0, OFS_PERIOD, 0);
    chk("period reset", q, {16'h0, PERIOD_RST});
    apb(0, 8'h20, 0);
    chk("unmapped error", err, 1'b1);
    $display("test reset done");
    apb(1, OFS_INTEN, 32'h8);
    apb(1, OFS_CTRL, 32'h0000_4003);
    apb(1, OFS_TXDATA, 32'h8123_4567);
    wait_words(1);
    chk("mosi word", got, 32'h8123_4567);
    apb(0, OFS_RXDATA, 0);
    chk("miso word", q, REPLY);
    chk("select idle", ss_out, 4'hF);
    chk("irq done", irq, 1'b1);
    apb(1, OFS_INTCLR, 32'h8);
    repeat (2) @(posedge pclk);
    chk("irq cleared", irq, 1'b0);
    $display("test master word done");
    peer_ready <= 1'b0;
    apb(1, OFS_CTRL, 32'h0000_4203);
    apb(1, OFS_TXDATA, 32'h7E00_0001);
    repeat (200) @(posedge pclk);
    apb(0, OFS_STAT, 0);
    chk("held tx count", q[3:0], 4'h1);
    peer_ready <= 1'b1;
    wait_words(2);
    chk("ready word", got, 32'h7E00_0001);
    $display("test ready done");
    apb(1, OFS_CTRL, 32'h0030_4102);
    for (i = 0; i < 9; i++) apb(1, OFS_TXDATA, 32'h1000_0000 + i);
    apb(0, OFS_STAT, 0);
    chk("tx count full", q[3:0], 4'h8);
    chk("tx dma full", tx_dma_req, 1'b0);
    f0 = frames;
    apb(1, OFS_CTRL, 32'h0030_4103);
    wait_words(10);
    chk("one frame", frames - f0, 1);
    chk("last word", got, 32'h1000_0007);
    apb(0, OFS_STAT, 0);
    chk("rx count full", q[11:8], 4'h8);
    chk("tx dma", tx_dma_req, 1'b1);
    chk("rx dma", rx_dma_req, 1'b1);
    apb(0, OFS_INTST, 0);
    chk("overflow", q[I_OVF], 1'b1);
    apb(1, OFS_INTEN, 32'h4);
    repeat (2) @(posedge pclk);
    chk("irq overflow", irq, 1'b1);
    apb(1, OFS_INTEN, 32'h0);
    repeat (2) @(posedge pclk);
    chk("irq masked", irq, 1'b0);
    apb(1, OFS_INTCLR, 32'h4);
    for (i = 0; i < 8; i++) begin
      apb(0, OFS_RXDATA, 0);
      chk("rx drain", q, REPLY);
    end
    apb(0, OFS_RXDATA, 0);
    chk("rx empty", q, 32'h0);
    chk("rx dma empty", rx_dma_req, 1'b0);
    chk("select held", ss_out[0], 1'b0);
    apb(1, OFS_CTRL, 32'h0000_4003);
    repeat (4) @(posedge pclk);
    chk("select released", ss_out, 4'hF);
    $display("test queues done");
    apb(1, OFS_CTRL, 32'h0000_4C03);
    apb(1, OFS_TXDATA, 32'h0F0F_0F0F);
    for (i = 0; i < 100 && ss_out === 4'hF; i++) @(posedge pclk);
    chk("select three", ss_out, 4'h7);
    repeat (400) @(posedge pclk);
    apb(0, OFS_RXDATA, 0);
    $display("test select done");
    for (m = 0; m < 2; m++) begin
      apb(1, OFS_CTRL, 32'h0000_2001 | (m << C_CPOL));
      apb(1, OFS_TXDATA, 32'h3C5A_96E1);
      slave_frame(m[0], 32'h9ABC_DEF0 ^ m, 32'h3C5A_96E1);
      repeat (4) @(posedge pclk);
      apb(0, OFS_RXDATA, 0);
      chk("slave rx", q, 32'h9ABC_DEF0 ^ m);
      chk("miso_oe off", miso_oe, 1'b0);
    end
    $display("test slave done");
    print_verdict();
  end
endmodule : csp_top_tb_top
